// >>> hdl/usd_cfg.svh
`ifndef USD_CFG_SVH
`define USD_CFG_SVH

// ----------------------------------------------------------------------
// string descriptor serving
// ----------------------------------------------------------------------
`define USD_STR_IDX_MIN   3'd1
`define USD_STR_IDX_MAX   3'd5
`define USD_STR_TBL_BASE  8'h10
`define USD_STR_BODY_OFS  8'h02

// ----------------------------------------------------------------------
// endpoint companion descriptor layout and fixed values
// ----------------------------------------------------------------------
`define USD_COMP_OFS_LEN   3'd0
`define USD_COMP_OFS_TYPE  3'd1
`define USD_COMP_OFS_BURST 3'd2
`define USD_COMP_OFS_ATTR  3'd3
`define USD_COMP_OFS_BPI_L 3'd4
`define USD_COMP_OFS_BPI_H 3'd5
`define USD_COMP_LEN       8'h06
`define USD_COMP_TYPE      8'h30
`define USD_BURST_RST      4'h3
`define USD_BULK_ATTR      8'h00
`define USD_BULK_BPI       16'h0000
`define USD_INTR_BURST     8'h00
`define USD_INTR_ATTR      8'h00
`define USD_INTR_BPI       16'h0004

`endif

// >>> hdl/usd_pkg.sv
package usd_pkg;

  // descriptor family asked for by the control read
  typedef enum logic {
    USD_KIND_STRING,
    USD_KIND_COMPANION
  } usd_kind_t;

  // endpoint whose companion descriptor is returned
  typedef enum logic [1:0] {
    USD_EP_BULK_IN,
    USD_EP_BULK_OUT,
    USD_EP_INTR
  } usd_ep_t;

  typedef enum logic [2:0] {
    USD_ST_IDLE,
    USD_ST_TBL_LEN,
    USD_ST_TBL_OFS,
    USD_ST_STR_RD,
    USD_ST_STR_HOLD,
    USD_ST_COMP
  } usd_state_t;

endpackage

// >>> hdl/usd_comp_if.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------
// byte lookup link between the fsm and the companion generator
// ----------------------------------------------------------------------
interface usd_comp_if;
  logic [2:0]        idx;
  usd_pkg::usd_ep_t  ep;
  logic [3:0]        burst_in;
  logic [3:0]        burst_out;
  logic [7:0]        data;

  modport gen  (input idx, input ep, input burst_in, input burst_out, output data);
  modport user (output idx, output ep, output burst_in, output burst_out, input data);
endinterface

`default_nettype wire

// >>> hdl/usd_companion.sv
`timescale 1ns/1ps
`default_nettype none

`include "usd_cfg.svh"

// ----------------------------------------------------------------------
// companion descriptor bytes from fixed values and the burst limits, nothing comes from the store
// ----------------------------------------------------------------------
module usd_companion (
  usd_comp_if.gen cif
);

  logic [7:0]  burst_byte;
  logic [7:0]  attr_byte;
  logic [15:0] bpi_word;

  // per-endpoint fields; burst byte is length minus one, 4 bits keep it 0..15
  always_comb begin
    burst_byte = `USD_INTR_BURST;                        // [RULE_12]
    attr_byte  = `USD_INTR_ATTR;                         // [RULE_12]
    bpi_word   = `USD_INTR_BPI;                          // [RULE_13]
    case (cif.ep)
      usd_pkg::USD_EP_BULK_IN: begin
        burst_byte = {4'h0, cif.burst_in};               // [RULE_07] [RULE_09]
        attr_byte  = `USD_BULK_ATTR;                     // [RULE_10]
        bpi_word   = `USD_BULK_BPI;                      // [RULE_11]
      end
      usd_pkg::USD_EP_BULK_OUT: begin
        burst_byte = {4'h0, cif.burst_out};              // [RULE_08] [RULE_09]
        attr_byte  = `USD_BULK_ATTR;                     // [RULE_10]
        bpi_word   = `USD_BULK_BPI;                      // [RULE_11]
      end
      default: begin
        burst_byte = `USD_INTR_BURST;
        attr_byte  = `USD_INTR_ATTR;
        bpi_word   = `USD_INTR_BPI;
      end
    endcase
  end

  // byte order on the wire, word fields little endian
  always_comb begin
    case (cif.idx)
      `USD_COMP_OFS_LEN:   cif.data = `USD_COMP_LEN;    // [RULE_06] [RULE_14]
      `USD_COMP_OFS_TYPE:  cif.data = `USD_COMP_TYPE;   // [RULE_06] [RULE_14]
      `USD_COMP_OFS_BURST: cif.data = burst_byte;       // [RULE_14]
      `USD_COMP_OFS_ATTR:  cif.data = attr_byte;        // [RULE_14]
      `USD_COMP_OFS_BPI_L: cif.data = bpi_word[7:0];    // [RULE_14]
      `USD_COMP_OFS_BPI_H: cif.data = bpi_word[15:8];   // [RULE_14]
      default:             cif.data = 8'h00;
    endcase
  end

endmodule

`default_nettype wire

// >>> hdl/usd_top.sv
// What this block does
// [RULE_01] strings 1..5 take length, type and body wholly from the store
// [RULE_02] string body starts at byte two, two bytes per character, no null
// [RULE_03] no valid store, or zero length and offset entry: stall data stage
// [RULE_04] stored string bytes go out verbatim, length and type unchecked
// [RULE_05] store writer keeps length and type bytes consistent with the table
// [RULE_06] every companion descriptor is six bytes, type 30h, fixed values
// [RULE_07] bulk-in burst byte resets to 03h, follows the bulk-in burst limit
// [RULE_08] bulk-out burst byte resets to 03h, replaceable by bulk-out limit
// [RULE_09] burst byte is burst length minus one, only 0 to 15
// [RULE_10] bulk companion attributes byte at offset three reads 00h
// [RULE_11] bulk companion bytes-per-interval at offset four reads zero
// [RULE_12] interrupt companion burst and attributes bytes read 00h
// [RULE_13] interrupt companion bytes-per-interval reads 0004h
// [RULE_14] companion order: length, type, burst, attributes, bytes-per-interval
// [RULE_15] language id of string requests is ignored
// [RULE_16] companion descriptors only at superspeed, otherwise stalled
// [RULE_17] burst limits are sampled when the request is taken

`timescale 1ns/1ps
`default_nettype none

`include "usd_cfg.svh"

module usd_top (
  input  wire logic             clk,
  input  wire logic             rst_b,
  // request from the control endpoint
  input  wire logic             req_valid,
  input  wire usd_pkg::usd_kind_t req_kind,
  input  wire logic [2:0]       req_str_idx,
  input  wire usd_pkg::usd_ep_t req_ep,
  input  wire logic             superspeed,
  // burst-limit fields of usb_config_reg_zero
  input  wire logic [3:0]       bulk_in_burst_limit,
  input  wire logic [3:0]       bulk_out_burst_limit,
  input  wire logic             bulk_out_burst_override,
  // nonvolatile configuration store read port
  input  wire logic             store_ok,
  output logic                  nv_rd_q,
  output logic [7:0]            nv_addr_q,
  input  wire logic [7:0]       nv_rd_data,
  // data stage byte stream
  output logic                  resp_valid_q,
  output logic [7:0]            resp_byte_q,
  output logic                  resp_last_q,
  input  wire logic             resp_ready,
  output logic                  resp_stall_q,
  output logic                  resp_done_q,
  output logic                  busy_q
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  usd_pkg::usd_state_t state_q;
  usd_pkg::usd_ep_t    ep_q;
  logic [3:0]          burst_in_q;
  logic [3:0]          burst_out_q;
  logic [7:0]          len_q;
  logic [7:0]          cnt_q;
  logic                rd_pend_q;
  logic                str_idx_ok;

  usd_comp_if cif ();

  usd_companion u_companion (
    .cif (cif)
  );

  assign cif.idx       = cnt_q[2:0];
  assign cif.ep        = ep_q;
  assign cif.burst_in  = burst_in_q;
  assign cif.burst_out = burst_out_q;

  // language id is not even a port: any language gets the string [RULE_15]
  assign str_idx_ok = (req_str_idx >= `USD_STR_IDX_MIN) && (req_str_idx <= `USD_STR_IDX_MAX);

  // ----------------------------------------------------------------------
  // request capture
  // ----------------------------------------------------------------------
  // limits are frozen per request so a descriptor never mixes two settings
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ep_q        <= usd_pkg::USD_EP_BULK_IN;
      burst_in_q  <= `USD_BURST_RST;                    // [RULE_07]
      burst_out_q <= `USD_BURST_RST;                    // [RULE_08]
    end else if (req_valid && state_q == usd_pkg::USD_ST_IDLE) begin
      ep_q        <= req_ep;
      burst_in_q  <= bulk_in_burst_limit;               // [RULE_07] [RULE_17]
      // without the override the bulk-out burst keeps its default
      burst_out_q <= bulk_out_burst_override ? bulk_out_burst_limit
                                             : `USD_BURST_RST; // [RULE_08] [RULE_17]
    end
  end

  // store answers one cycle after the read strobe
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_pend_q <= 1'b0;
    end else begin
      rd_pend_q <= nv_rd_q;
    end
  end

  // ----------------------------------------------------------------------
  // request sequencer and byte stream
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q      <= usd_pkg::USD_ST_IDLE;
      len_q        <= 8'h00;
      cnt_q        <= 8'h00;
      nv_rd_q      <= 1'b0;
      nv_addr_q    <= 8'h00;
      resp_valid_q <= 1'b0;
      resp_byte_q  <= 8'h00;
      resp_last_q  <= 1'b0;
      resp_stall_q <= 1'b0;
      resp_done_q  <= 1'b0;
    end else begin
      nv_rd_q      <= 1'b0;
      resp_stall_q <= 1'b0;
      resp_done_q  <= 1'b0;
      case (state_q)
        usd_pkg::USD_ST_IDLE: begin
          if (req_valid) begin
            if (req_kind == usd_pkg::USD_KIND_STRING) begin
              if (!store_ok || !str_idx_ok) begin
                resp_stall_q <= 1'b1;                   // [RULE_03]
              end else begin
                // table holds a length byte then an offset byte per string
                nv_addr_q <= `USD_STR_TBL_BASE + {4'h0, req_str_idx - 3'd1, 1'b0};
                nv_rd_q   <= 1'b1;                      // [RULE_01]
                state_q   <= usd_pkg::USD_ST_TBL_LEN;
              end
            end else if (!superspeed) begin
              resp_stall_q <= 1'b1;                     // [RULE_16]
            end else begin
              cnt_q   <= 8'h00;
              state_q <= usd_pkg::USD_ST_COMP;          // [RULE_06]
            end
          end
        end
        usd_pkg::USD_ST_TBL_LEN: begin
          if (rd_pend_q) begin
            len_q     <= nv_rd_data;                    // [RULE_05]
            nv_addr_q <= nv_addr_q + 8'h01;
            nv_rd_q   <= 1'b1;
            state_q   <= usd_pkg::USD_ST_TBL_OFS;
          end
        end
        usd_pkg::USD_ST_TBL_OFS: begin
          if (rd_pend_q) begin
            if (len_q == 8'h00 && nv_rd_data == 8'h00) begin
              resp_stall_q <= 1'b1;                     // [RULE_03]
              state_q      <= usd_pkg::USD_ST_IDLE;
            end else if (len_q == 8'h00) begin
              // an offset with no bytes yields an empty data stage
              resp_done_q <= 1'b1;
              state_q     <= usd_pkg::USD_ST_IDLE;
            end else begin
              // the stored area already holds length and type in front
              nv_addr_q <= nv_rd_data;                  // [RULE_01] [RULE_02]
              nv_rd_q   <= 1'b1;
              cnt_q     <= 8'h00;
              state_q   <= usd_pkg::USD_ST_STR_RD;
            end
          end
        end
        usd_pkg::USD_ST_STR_RD: begin
          if (rd_pend_q) begin
            resp_valid_q <= 1'b1;
            resp_byte_q  <= nv_rd_data;                 // [RULE_04] [RULE_02]
            resp_last_q  <= (cnt_q == len_q - 8'h01);
            cnt_q        <= cnt_q + 8'h01;
            state_q      <= usd_pkg::USD_ST_STR_HOLD;
          end
        end
        usd_pkg::USD_ST_STR_HOLD: begin
          // one byte in flight at a time; the host side sets the pace
          if (resp_ready) begin
            resp_valid_q <= 1'b0;
            if (resp_last_q) begin
              resp_last_q <= 1'b0;
              resp_done_q <= 1'b1;
              state_q     <= usd_pkg::USD_ST_IDLE;
            end else begin
              nv_addr_q <= nv_addr_q + 8'h01;
              nv_rd_q   <= 1'b1;
              state_q   <= usd_pkg::USD_ST_STR_RD;
            end
          end
        end
        usd_pkg::USD_ST_COMP: begin
          if (!resp_valid_q || resp_ready) begin
            if (resp_valid_q && resp_last_q) begin
              resp_valid_q <= 1'b0;
              resp_last_q  <= 1'b0;
              resp_done_q  <= 1'b1;
              state_q      <= usd_pkg::USD_ST_IDLE;
            end else begin
              resp_valid_q <= 1'b1;
              resp_byte_q  <= cif.data;                 // [RULE_14]
              resp_last_q  <= (cnt_q[2:0] == `USD_COMP_OFS_BPI_H);
              cnt_q        <= cnt_q + 8'h01;
            end
          end
        end
        default: begin
          state_q <= usd_pkg::USD_ST_IDLE;
        end
      endcase
    end
  end

  // busy from one cycle after the taken request until one cycle after the stream ends
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= (state_q != usd_pkg::USD_ST_IDLE);
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  a_no_store_stall: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_03]
    state_q == usd_pkg::USD_ST_IDLE && req_valid && req_kind == usd_pkg::USD_KIND_STRING
    && !store_ok |=> resp_stall_q && state_q == usd_pkg::USD_ST_IDLE)
    else $error("string read without store was not stalled");

  a_zero_entry_stall: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_03]
    state_q == usd_pkg::USD_ST_TBL_OFS && rd_pend_q && len_q == 8'h00
    && nv_rd_data == 8'h00 |=> resp_stall_q && !resp_valid_q)
    else $error("empty string entry was not stalled");

  a_low_speed_stall: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_16]
    state_q == usd_pkg::USD_ST_IDLE && req_valid && req_kind == usd_pkg::USD_KIND_COMPANION
    && !superspeed |=> resp_stall_q ##1 !resp_valid_q)
    else $error("companion returned below superspeed");

  a_str_verbatim: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_04]
    state_q == usd_pkg::USD_ST_STR_RD && rd_pend_q
    |=> resp_valid_q && resp_byte_q == $past(nv_rd_data))
    else $error("string byte differs from stored byte");

  a_comp_first_len: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_06]
    state_q == usd_pkg::USD_ST_IDLE && req_valid && req_kind == usd_pkg::USD_KIND_COMPANION
    && superspeed |-> ##2 resp_valid_q && resp_byte_q == `USD_COMP_LEN)
    else $error("companion does not open with length six");

  a_comp_type_byte: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_14]
    state_q == usd_pkg::USD_ST_COMP && resp_valid_q && cnt_q == 8'h02
    |-> resp_byte_q == `USD_COMP_TYPE)
    else $error("companion type byte misplaced");

  a_bulk_attr_zero: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_10]
    state_q == usd_pkg::USD_ST_COMP && resp_valid_q && cnt_q == 8'h04
    && ep_q != usd_pkg::USD_EP_INTR |-> resp_byte_q == `USD_BULK_ATTR)
    else $error("bulk companion attributes not zero");

  a_intr_bpi_low: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_13]
    state_q == usd_pkg::USD_ST_COMP && resp_valid_q && cnt_q == 8'h05
    && ep_q == usd_pkg::USD_EP_INTR |-> resp_byte_q == 8'(`USD_INTR_BPI))
    else $error("interrupt bytes per interval wrong");

  a_burst_sampled: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_17]
    state_q == usd_pkg::USD_ST_IDLE && req_valid
    |=> burst_in_q == $past(bulk_in_burst_limit))
    else $error("bulk-in burst limit not sampled at request");

  a_hold_stable: assert property (@(posedge clk) disable iff (!rst_b)
    resp_valid_q && !resp_ready |=> resp_valid_q && $stable(resp_byte_q))
    else $error("byte changed while not accepted");

  a_comp_six_bytes: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_06]
    state_q == usd_pkg::USD_ST_COMP && resp_valid_q && resp_last_q |-> cnt_q == 8'h06)
    else $error("companion length is not six bytes");

  a_bulk_in_burst: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_07]
    state_q == usd_pkg::USD_ST_COMP && resp_valid_q && cnt_q == 8'h03
    && ep_q == usd_pkg::USD_EP_BULK_IN |-> resp_byte_q == {4'h0, burst_in_q})
    else $error("bulk-in burst byte not from its limit");

  a_intr_burst_zero: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_12]
    state_q == usd_pkg::USD_ST_COMP && resp_valid_q && cnt_q == 8'h03
    && ep_q == usd_pkg::USD_EP_INTR |-> resp_byte_q == `USD_INTR_BURST)
    else $error("interrupt burst byte not zero");

  a_bulk_bpi_zero: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_11]
    state_q == usd_pkg::USD_ST_COMP && resp_valid_q && cnt_q >= 8'h05
    && ep_q != usd_pkg::USD_EP_INTR |-> resp_byte_q == 8'h00)
    else $error("bulk bytes per interval not zero");

endmodule

`default_nettype wire

// >>> bench/usd_store_model.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------
// nonvolatile configuration store, one-cycle read latency
// ----------------------------------------------------------------------
module usd_store_model (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       nv_rd,
  input  wire logic [7:0] nv_addr,
  output logic [7:0]      nv_rd_data
);
  logic [7:0] mem [0:255];

  // table entries: length byte then offset byte, only string 1 has a header that agrees with its length
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'h00;
    end
    mem[8'h10] = 8'h04;
    mem[8'h11] = 8'h40;
    mem[8'h14] = 8'h00;
    mem[8'h15] = 8'h50;
    mem[8'h16] = 8'h02;
    mem[8'h17] = 8'h60;
    mem[8'h18] = 8'h01;
    mem[8'h19] = 8'h70;
    mem[8'h40] = 8'h04;
    mem[8'h41] = 8'h03;
    mem[8'h42] = 8'h41;
    mem[8'h43] = 8'h00;
    // deliberately inconsistent header, the block must pass it on as stored
    mem[8'h60] = 8'h09;
    mem[8'h61] = 8'h07;
    mem[8'h70] = 8'h5a;
  end

  // data valid only in the cycle after the strobe; otherwise it keeps flipping
  // so that a late sample never sees a plausible value
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      nv_rd_data <= 8'h00;
    end else if (nv_rd) begin
      nv_rd_data <= mem[nv_addr];
    end else begin
      nv_rd_data <= ~nv_rd_data;
    end
  end
endmodule

`default_nettype wire

// >>> bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic                clk, rst_b, req_valid, superspeed, bulk_out_burst_override;
  logic                store_ok, resp_ready, slow, chg_lim;
  logic                nv_rd_q, resp_valid_q, resp_last_q, resp_stall_q, resp_done_q, busy_q;
  usd_pkg::usd_kind_t  req_kind;
  usd_pkg::usd_ep_t    req_ep;
  logic [2:0]          req_str_idx;
  logic [3:0]          bulk_in_burst_limit, bulk_out_burst_limit;
  logic [7:0]          nv_rd_data, nv_addr_q, resp_byte_q;
  logic [7:0]          exp_q[$];
  int                  err_total, num_checks, cycles;

  usd_top u_dut (
    .clk(clk), .rst_b(rst_b), .req_valid(req_valid), .req_kind(req_kind),
    .req_str_idx(req_str_idx), .req_ep(req_ep), .superspeed(superspeed),
    .bulk_in_burst_limit(bulk_in_burst_limit), .bulk_out_burst_limit(bulk_out_burst_limit),
    .bulk_out_burst_override(bulk_out_burst_override), .store_ok(store_ok),
    .nv_rd_q(nv_rd_q), .nv_addr_q(nv_addr_q), .nv_rd_data(nv_rd_data),
    .resp_valid_q(resp_valid_q), .resp_byte_q(resp_byte_q), .resp_last_q(resp_last_q),
    .resp_ready(resp_ready), .resp_stall_q(resp_stall_q), .resp_done_q(resp_done_q),
    .busy_q(busy_q)
  );

  usd_store_model u_store (
    .clk(clk), .rst_b(rst_b), .nv_rd(nv_rd_q), .nv_addr(nv_addr_q), .nv_rd_data(nv_rd_data)
  );

  // ----------------------------------------------------------------------
  // clock, watchdog and verdict
  // ----------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // whole run is a few hundred cycles, so 5000 only trips on a hang
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      err_total++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    if (err_total == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // ----------------------------------------------------------------------
  // one control read: issue, drain the data stage, judge it
  // ----------------------------------------------------------------------
  task automatic run(input usd_pkg::usd_kind_t k, input logic [2:0] idx,
                     input usd_pkg::usd_ep_t ep, input logic exp_stall);
    int   n;
    int   got;
    logic stalled;
    logic fin;
    got = 0;
    stalled = 1'b0;
    fin = 1'b0;
    @(posedge clk);
    req_valid <= 1'b1;
    req_kind <= k;
    req_str_idx <= idx;
    req_ep <= ep;
    @(posedge clk);
    req_valid <= 1'b0;
    // limit moves right after the taking edge; only the next read may see it
    if (chg_lim) begin
      bulk_in_burst_limit <= 4'h9;
    end
    for (n = 0; n < 100 && !fin; n++) begin
      @(negedge clk);
      if (n == 0) begin
        chk({7'h00, busy_q}, 8'h00);
      end
      if (resp_stall_q === 1'b1) begin
        stalled = 1'b1;
        fin = 1'b1;
      end else if (resp_done_q === 1'b1) begin
        fin = 1'b1;
      end else if (resp_valid_q === 1'b1 && resp_ready === 1'b1) begin
        chk(resp_byte_q, exp_q[got]);
        chk({7'h00, busy_q}, 8'h01);
        chk({7'h00, resp_last_q}, {7'h00, got == exp_q.size() - 1});
        got++;
      end
      @(posedge clk);
      resp_ready <= slow ? ~resp_ready : 1'b1;
    end
    chk({7'h00, fin}, 8'h01);
    chk({7'h00, stalled}, {7'h00, exp_stall});
    chk(8'(got), 8'(exp_q.size()));
  endtask

  task automatic comp(input usd_pkg::usd_ep_t ep, input logic [7:0] burst,
                      input logic [7:0] bpi);
    exp_q = '{8'h06, 8'h30, burst, 8'h00, bpi, 8'h00};
    run(usd_pkg::USD_KIND_COMPANION, 3'h0, ep, 1'b0);
  endtask

  task automatic str(input logic [2:0] idx, input logic exp_stall);
    run(usd_pkg::USD_KIND_STRING, idx, usd_pkg::USD_EP_BULK_IN, exp_stall);
  endtask

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  // bulk companions: default, field-driven and override-driven burst bytes
  task automatic t_comp_bulk();
    comp(usd_pkg::USD_EP_BULK_IN, 8'h03, 8'h00);
    @(posedge clk);
    bulk_in_burst_limit <= 4'h0;
    comp(usd_pkg::USD_EP_BULK_IN, 8'h00, 8'h00);
    comp(usd_pkg::USD_EP_BULK_OUT, 8'h03, 8'h00);
    @(posedge clk);
    bulk_out_burst_override <= 1'b1;
    bulk_out_burst_limit <= 4'hf;
    comp(usd_pkg::USD_EP_BULK_OUT, 8'h0f, 8'h00);
  endtask

  // interrupt companion, consumer accepts every other cycle
  task automatic t_comp_intr_slow();
    slow = 1'b1;
    comp(usd_pkg::USD_EP_INTR, 8'h00, 8'h04);
    slow = 1'b0;
  endtask

  // a limit moved after the taking edge shows only in the next read
  task automatic t_burst_sampling();
    @(posedge clk);
    bulk_in_burst_limit <= 4'h5;
    chg_lim = 1'b1;
    comp(usd_pkg::USD_EP_BULK_IN, 8'h05, 8'h00);
    chg_lim = 1'b0;
    comp(usd_pkg::USD_EP_BULK_IN, 8'h09, 8'h00);
  endtask

  // companion asked for below superspeed
  task automatic t_low_speed();
    @(posedge clk);
    superspeed <= 1'b0;
    exp_q = {};
    run(usd_pkg::USD_KIND_COMPANION, 3'h0, usd_pkg::USD_EP_INTR, 1'b1);
    @(posedge clk);
    superspeed <= 1'b1;
  endtask

  // strings that exist, including an empty one and a bad header
  task automatic t_str_served();
    exp_q = '{8'h04, 8'h03, 8'h41, 8'h00};
    str(3'h1, 1'b0);
    slow = 1'b1;
    str(3'h1, 1'b0);
    slow = 1'b0;
    exp_q = {};
    str(3'h3, 1'b0);
    exp_q = '{8'h09, 8'h07};
    str(3'h4, 1'b0);
    exp_q = '{8'h5a};
    str(3'h5, 1'b0);
  endtask

  // strings that must stall: zero entry, bad index, no store
  task automatic t_str_refused();
    exp_q = {};
    str(3'h2, 1'b1);
    str(3'h0, 1'b1);
    str(3'h6, 1'b1);
    @(posedge clk);
    store_ok <= 1'b0;
    str(3'h1, 1'b1);
  endtask

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    rst_b = 1'b0;
    req_valid = 1'b0;
    req_kind = usd_pkg::USD_KIND_STRING;
    req_ep = usd_pkg::USD_EP_BULK_IN;
    req_str_idx = 3'h0;
    superspeed = 1'b1;
    bulk_in_burst_limit = 4'h3;
    bulk_out_burst_limit = 4'h9;
    bulk_out_burst_override = 1'b0;
    store_ok = 1'b1;
    resp_ready = 1'b1;
    slow = 1'b0;
    chg_lim = 1'b0;
    err_total = 0;
    num_checks = 0;
    cycles = 0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    t_comp_bulk();
    t_comp_intr_slow();
    t_burst_sampling();
    t_low_speed();
    t_str_served();
    t_str_refused();
    end_of_test();
  end
endmodule

`default_nettype wire
